// file: design/acr_pkg.sv
// Purpose: Shared constants for the converter control block.
// Assumes: APB slave at 32-bit data, single clock pclk.
// Notes: Register offsets are byte addresses of aligned words.
//
// Overview of operation
// - Done flag sets per conversion when interrupts off
// - Status write, result read, reset clear done
// - Interrupts enabled: done never set, reads zero
// - Interrupt raised per conversion, dropped by status write or result read
// - Continuous bit repeats conversions, else one only
// - Codes zero to fourteen pick external channels
// - Codes 29, 30 pick high, low reference
// - Unused codes give an undefined result
// - All-ones channel code powers converter off
// - Eight-bit result updated on every completion
// - Prescaler divides by 1, 2, 4, 8, 16
// - Source bit: one bus clock, zero reference
// - A conversion lasts sixteen converter clocks
// - Start on first converter clock after write
// - Continuous results overwrite unread ones
// - Stop mode aborts, conversion restarts after exit
package acr_pkg;
    // =========================================================
    // Register map
    localparam logic [7:0] ACR_OFS_STATUS = 8'h00;
    localparam logic [7:0] ACR_OFS_RESULT = 8'h04;
    localparam logic [7:0] ACR_OFS_CLKSEL = 8'h08;
    // =========================================================
    // Field positions
    localparam int ACR_DONE_BIT = 7;
    localparam int ACR_IRQEN_BIT = 6;
    localparam int ACR_CONT_BIT = 5;
    localparam int ACR_DIV_LSB = 5;
    localparam int ACR_SRC_BIT = 4;
    // =========================================================
    // Reset values and channel codes
    localparam logic [4:0] ACR_CHAN_RST = 5'h1F;
    localparam logic [2:0] ACR_DIV_RST = 3'h0;
    localparam logic ACR_SRC_RST = 1'b0;
    localparam logic [4:0] ACR_CHAN_OFF = 5'h1F;
    localparam logic [4:0] ACR_CHAN_LAST_EXT = 5'h0E;
    localparam logic [4:0] ACR_CHAN_REF_HI = 5'h1D;
    localparam logic [4:0] ACR_CHAN_REF_LO = 5'h1E;
    // =========================================================
    // Conversion timing in converter clocks
    localparam logic [3:0] ACR_LAST_TICK = 4'hF;
    localparam logic [4:0] ACR_CONV_TICKS = 5'h10;
    localparam logic [3:0] ACR_FIRST_BIT_TICK = 4'h8;
    typedef enum logic {
        ACR_IDLE = 1'b0,
        ACR_CONV = 1'b1
    } acr_sar_state_t;
endpackage

// file: design/acr_clk_gen.sv
// Purpose: Converter clock enable from a selectable, divided source.
// Assumes: The reference clock is far slower than pclk.
// Notes: The tick output is a one-cycle enable, not a real clock.
module acr_clk_gen
    import acr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_ref_clk,
    input wire logic src_bus,
    input wire logic [2:0] div_code,
    input wire logic run,
    output logic tick
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic tick_next;
    wire [3:0] last_cnt;
    wire src_edge;

    // =========================================================
    // Divide code to terminal count; top bit set means sixteen.
    function automatic logic [3:0] div_last(input logic [2:0] code);
        logic [3:0] r;
        r = code[2] ? 4'hF : 4'((5'h01 << code[1:0]) - 5'h01);
        return r;
    endfunction

    // Reference clock passes two flops before edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= ext_ref_clk;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Source choice and prescale terminal count.
    assign src_edge = src_bus ? 1'b1 : (s2_reg & ~s3_reg);
    assign last_cnt = div_last(div_code);

    always_comb begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (!run) begin
            cnt_next = 4'h0;
        end else if (src_edge) begin
            if (cnt_reg >= last_cnt) begin
                cnt_next = 4'h0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 4'h0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end

    a_div_terminal: assert property (
        @(posedge pclk) disable iff (!presetn)
        run && src_edge && cnt_reg == last_cnt |=> tick)
        else $error("prescaler missed its terminal count");
endmodule

// file: design/acr_sar.sv
// Purpose: Successive approximation sequencer, sixteen ticks each.
// Assumes: cmp_above is settled by the tick after a trial change.
// Notes: Eight sampling ticks precede eight bit decisions.
module acr_sar
    import acr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic cmp_above,
    output logic busy,
    output logic done,
    output logic [7:0] trial,
    output logic [7:0] result
);
    acr_sar_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] trial_next;
    logic [4:0] ticks_seen_reg;
    wire [2:0] bit_idx;
    wire take;
    wire step;

    assign take = state_reg == ACR_IDLE && start && tick && !abort;
    assign step = state_reg == ACR_CONV && tick && !abort;
    assign bit_idx = ~cnt_reg[2:0];
    assign busy = state_reg == ACR_CONV;

    // Decide one bit, then try the next lower one.
    always_comb begin
        trial_next = trial;
        if (cnt_reg >= ACR_FIRST_BIT_TICK) begin
            trial_next[bit_idx] = cmp_above;
            if (bit_idx != 3'h0) begin
                trial_next[3'(bit_idx - 3'h1)] = 1'b1;
            end
        end
    end

    // Sequencer; abort returns to idle without a result.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ACR_IDLE;
            cnt_reg <= 4'h0;
            trial <= 8'h00;
            result <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_reg)
                ACR_IDLE: begin
                    if (take) begin
                        state_reg <= ACR_CONV;
                        cnt_reg <= 4'h0;
                        trial <= 8'h80;
                    end
                end
                ACR_CONV: begin
                    if (abort) begin
                        state_reg <= ACR_IDLE;
                    end else if (step) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        trial <= trial_next;
                        if (cnt_reg == ACR_LAST_TICK) begin
                            state_reg <= ACR_IDLE;
                            result <= trial_next;
                            done <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Tick count of the current conversion, for checking only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks_seen_reg <= 5'h00;
        end else if (take) begin
            ticks_seen_reg <= 5'h00; // The starting tick only arms.
        end else if (step) begin
            ticks_seen_reg <= ticks_seen_reg + 5'h01;
        end
    end

    sequence s_first_decision;
        step && cnt_reg == ACR_FIRST_BIT_TICK;
    endsequence

    a_conv_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        done |-> ticks_seen_reg == ACR_CONV_TICKS)
        else $error("conversion did not take sixteen ticks");
    a_msb_first: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_first_decision |=> trial[7] == $past(cmp_above) && trial[6])
        else $error("first decision was not the top bit");
    a_result_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        step && cnt_reg == ACR_LAST_TICK |=> done && result == trial)
        else $error("result not loaded at completion");
endmodule

// file: design/acr_top.sv
// Purpose: Register file and control of an 8-bit converter.
// Assumes: APB master per the public protocol; pclk 50 MHz.
// Notes: One wait state on every access; pready comes from a flop.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
module acr_top
    import acr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_ref_clk,
    input wire logic stop_mode,
    input wire logic cmp_above,
    output logic [7:0] trial_code,
    output logic [4:0] input_channel_select,
    output logic ext_channel_en,
    output logic high_ref_sel,
    output logic low_ref_sel,
    output logic converter_power_on,
    output logic conv_irq
);
    // =========================================================
    // Control and status state
    logic conversion_done_flag_reg;
    logic conversion_done_flag_next;
    logic conversion_irq_enable_reg;
    logic continuous_convert_select_reg;
    logic [4:0] chan_reg;
    logic [2:0] converter_clock_divider_reg;
    logic converter_clock_source_select_reg;
    logic start_pend_reg;
    logic start_pend_next;
    logic conv_irq_next;
    logic [31:0] prdata_next;

    wire tick;
    wire sar_busy;
    wire sar_done;
    wire [7:0] conversion_result;

    // =========================================================
    // Bus decode
    // An access completes on the edge where pready is already high,
    // so every side effect below happens exactly once per transfer.
    wire acc = psel & penable & pready;
    wire sel_status = paddr == ACR_OFS_STATUS;
    wire sel_result = paddr == ACR_OFS_RESULT;
    wire sel_clksel = paddr == ACR_OFS_CLKSEL;
    wire mapped = sel_status | sel_result | sel_clksel;
    wire wr_status = acc & pwrite & sel_status;
    wire wr_clksel = acc & pwrite & sel_clksel;
    wire rd_result = acc & ~pwrite & sel_result;
    wire pready_next = psel & penable & ~pready;

    // Status and clock words as software reads them.
    wire [7:0] status_word = {
        conversion_done_flag_reg,
        conversion_irq_enable_reg,
        continuous_convert_select_reg,
        chan_reg
    };
    wire [7:0] clksel_word = {
        converter_clock_divider_reg,
        converter_clock_source_select_reg,
        4'h0
    };

    // =========================================================
    // Conversion control terms
    // Power off and stop both halt the prescaler so that no tick
    // can start a conversion while the analog side is down.
    wire power_off = chan_reg == ACR_CHAN_OFF;
    wire run_ok = ~power_off & ~stop_mode;
    wire wr_chan_off = wr_status & pwdata[4:0] == ACR_CHAN_OFF;
    wire sar_abort = stop_mode | power_off | wr_status;
    wire sar_take = tick & start_pend_reg & ~sar_busy & ~sar_abort;
    wire done_clr = wr_status | rd_result;
    wire done_set = sar_done & ~conversion_irq_enable_reg;
    wire irq_set = sar_done & conversion_irq_enable_reg;

    // =========================================================
    // Pending start request
    // A write arms a start that the next converter tick takes. A
    // conversion cut short by stop mode is re-armed so that it runs
    // again once stop mode ends.
    always_comb begin
        start_pend_next = start_pend_reg;
        if (sar_take) begin
            start_pend_next = 1'b0;
        end
        if (sar_done & continuous_convert_select_reg) begin
            start_pend_next = 1'b1;
        end
        if (stop_mode & sar_busy) begin
            start_pend_next = 1'b1;
        end
        if (wr_status) begin
            start_pend_next = ~wr_chan_off;
        end
        if (power_off & ~wr_status) begin
            start_pend_next = 1'b0;
        end
    end

    // =========================================================
    // Done flag and interrupt request
    // A completion in the same cycle as a clearing access wins unless that access
    // is a status write setting interrupt enable, so no event is lost to a read that raced with it.
    always_comb begin
        conversion_done_flag_next = conversion_done_flag_reg;
        if (done_clr) begin
            conversion_done_flag_next = 1'b0;
        end
        if (done_set) begin
            conversion_done_flag_next = 1'b1;
        end
        if (wr_status & pwdata[ACR_IRQEN_BIT]) begin
            conversion_done_flag_next = 1'b0;
        end
    end

    always_comb begin
        conv_irq_next = conv_irq;
        if (done_clr) begin
            conv_irq_next = 1'b0;
        end
        if (irq_set) begin
            conv_irq_next = 1'b1;
        end
    end

    // =========================================================
    // Read data mux; unmapped offsets read zero with an error.
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (sel_status) begin
            prdata_next = {24'h000000, status_word};
        end else if (sel_result) begin
            prdata_next = {24'h000000, conversion_result};
        end else if (sel_clksel) begin
            prdata_next = {24'h000000, clksel_word};
        end
    end

    // =========================================================
    // Bus answer flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= pready_next;
            pslverr <= pready_next & ~mapped;
            prdata <= pready_next ? prdata_next : 32'h0000_0000;
        end
    end

    // =========================================================
    // Software-written registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_irq_enable_reg <= 1'b0;
            continuous_convert_select_reg <= 1'b0;
            chan_reg <= ACR_CHAN_RST;
        end else if (wr_status) begin
            conversion_irq_enable_reg <= pwdata[ACR_IRQEN_BIT];
            continuous_convert_select_reg <= pwdata[ACR_CONT_BIT];
            chan_reg <= pwdata[4:0];
        end
    end

    // Clock setup; changing it mid-conversion spoils that result.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_clock_divider_reg <= ACR_DIV_RST;
            converter_clock_source_select_reg <= ACR_SRC_RST;
        end else if (wr_clksel) begin
            converter_clock_divider_reg <= pwdata[ACR_DIV_LSB +: 3];
            converter_clock_source_select_reg <= pwdata[ACR_SRC_BIT];
        end
    end

    // =========================================================
    // Event state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_done_flag_reg <= 1'b0;
            conv_irq <= 1'b0;
            start_pend_reg <= 1'b0;
        end else begin
            conversion_done_flag_reg <= conversion_done_flag_next;
            conv_irq <= conv_irq_next;
            start_pend_reg <= start_pend_next;
        end
    end

    // =========================================================
    // Analog side controls, each from its own flop.
    // Unused codes still route nothing external; the comparator
    // then sees an undefined level and the result means nothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_channel_select <= ACR_CHAN_RST;
            ext_channel_en <= 1'b0;
            high_ref_sel <= 1'b0;
            low_ref_sel <= 1'b0;
            converter_power_on <= 1'b0;
        end else begin
            input_channel_select <= chan_reg;
            ext_channel_en <= chan_reg <= ACR_CHAN_LAST_EXT;
            high_ref_sel <= chan_reg == ACR_CHAN_REF_HI;
            low_ref_sel <= chan_reg == ACR_CHAN_REF_LO;
            converter_power_on <= ~power_off;
        end
    end

    // =========================================================
    // Converter clock and sequencer.
    acr_clk_gen u_clk_gen (
        .pclk(pclk),
        .presetn(presetn),
        .ext_ref_clk(ext_ref_clk),
        .src_bus(converter_clock_source_select_reg),
        .div_code(converter_clock_divider_reg),
        .run(run_ok),
        .tick(tick)
    );

    acr_sar u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .start(start_pend_reg),
        .abort(sar_abort),
        .cmp_above(cmp_above),
        .busy(sar_busy),
        .done(sar_done),
        .trial(trial_code), // No extra flop: a tick may follow at once.
        .result(conversion_result)
    );

    // =========================================================
    // Checks.
    sequence s_status_write;
        wr_status && !wr_chan_off;
    endsequence

    a_done_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_set |=> conversion_done_flag_reg)
        else $error("done flag not set after completion");

    a_done_holds: assert property (
        @(posedge pclk) disable iff (!presetn)
        conversion_done_flag_reg && !done_clr |=> conversion_done_flag_reg)
        else $error("done flag dropped without a clearing access");

    a_done_clears: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_clr && !sar_done |=> !conversion_done_flag_reg)
        else $error("done flag survived a clearing access");

    a_irq_no_done: assert property (
        @(posedge pclk) disable iff (!presetn)
        conversion_irq_enable_reg |-> !conversion_done_flag_reg)
        else $error("done flag set while interrupts enabled");

    a_irq_raise: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_set |=> conv_irq)
        else $error("interrupt not raised after completion");

    a_irq_clears: assert property (
        @(posedge pclk) disable iff (!presetn)
        done_clr && !irq_set |=> !conv_irq)
        else $error("interrupt survived a clearing access");

    a_cont_rearm: assert property (
        @(posedge pclk) disable iff (!presetn)
        sar_done && continuous_convert_select_reg && !wr_status
            && !power_off |=> start_pend_reg)
        else $error("continuous mode did not re-arm");

    a_power_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        power_off |=> !sar_busy && !converter_power_on)
        else $error("converter ran while powered off");

    a_ref_route: assert property (
        @(posedge pclk) disable iff (!presetn)
        chan_reg == ACR_CHAN_REF_HI |=> high_ref_sel && !ext_channel_en)
        else $error("high reference not routed alone");

    a_src_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_clksel |=> converter_clock_source_select_reg
            == $past(pwdata[ACR_SRC_BIT]))
        else $error("clock source bit not loaded");

    a_ready_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    a_write_arms: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_status_write |=> start_pend_reg && !sar_busy)
        else $error("status write did not arm a start");

    a_stop_abort: assert property (
        @(posedge pclk) disable iff (!presetn)
        stop_mode |=> !sar_busy)
        else $error("conversion continued in stop mode");
endmodule

// file: test/acr_cmp_model.sv
// Purpose: Analog mux and comparator facing the converter control block.
// Assumes: Channel n holds level 0x11*n+3 plus half a step.
// Notes: Off or unused codes give a pattern that flips every cycle.
module acr_cmp_model
    import acr_pkg::*;
(
    input wire logic pclk,
    input wire logic [7:0] trial_code,
    input wire logic [4:0] input_channel_select,
    input wire logic ext_channel_en,
    input wire logic high_ref_sel,
    input wire logic low_ref_sel,
    input wire logic converter_power_on,
    output logic cmp_above
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Input level
    logic [8:0] level;
    logic valid;
    logic flip = 1'b0;
    // Levels carry a half step so no trial code ever ties with them.
    always_comb begin
        level = 9'h000;
        if (high_ref_sel) begin
            level = 9'h1FF;
        end else if (low_ref_sel) begin
            level = 9'h001;
        end else if (ext_channel_en) begin
            level = {8'(8'h11 * input_channel_select + 8'h03), 1'b1};
        end
    end
    // Undefined input when unused or off, so a stale value cannot pass.
    assign valid = converter_power_on & (high_ref_sel | low_ref_sel |
        ext_channel_en);
    always_ff @(posedge pclk) flip <= ~flip;
    assign cmp_above = valid ? (level > {trial_code, 1'b0}) : flip;
endmodule

// file: test/testbench.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: Registers at 0x00, 0x04, 0x08; one APB wait state.
// Notes: Conversion times are checked within a window of cycles.
module testbench
    import acr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // Signals and instances
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic ext_ref_clk = 0, stop_mode = 0;
    logic [31:0] prdata;
    logic pready, pslverr, cmp_above, ext_channel_en, high_ref_sel;
    logic low_ref_sel, converter_power_on, conv_irq;
    logic [7:0] trial_code;
    logic [4:0] input_channel_select;
    int fails = 0, compares = 0, cyc = 0;
    acr_top u_acr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_ref_clk(ext_ref_clk),
        .stop_mode(stop_mode), .cmp_above(cmp_above),
        .trial_code(trial_code),
        .input_channel_select(input_channel_select),
        .ext_channel_en(ext_channel_en), .high_ref_sel(high_ref_sel),
        .low_ref_sel(low_ref_sel), .converter_power_on(converter_power_on),
        .conv_irq(conv_irq));
    acr_cmp_model u_acr_cmp_model (.pclk(pclk), .trial_code(trial_code),
        .input_channel_select(input_channel_select),
        .ext_channel_en(ext_channel_en), .high_ref_sel(high_ref_sel),
        .low_ref_sel(low_ref_sel), .converter_power_on(converter_power_on),
        .cmp_above(cmp_above));
    // The reference clock is unrelated in phase to pclk on purpose.
    initial forever #10 pclk = ~pclk;
    initial forever #37 ext_ref_clk = ~ext_ref_clk;
    // =========================================================
    // Shared tasks
    task automatic wrap_up();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk_rng(input int n, input int lo, input int hi);
        compares++;
        if (n < lo || n > hi) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
        end
    endtask
    // Entered just after an edge; one idle edge follows the release.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    task automatic wait_done();
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        r = 0;
        while (r[7] !== 1'b1 && n < 100) begin
            apb(1'b0, 8'h00, 32'h0, r, e);
            n++;
        end
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        while (conv_irq !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // =========================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rdchk(8'h00, 32'h1F);
        rdchk(8'h08, 32'h00);
        chk(converter_power_on, 1'b0);
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        wr(8'h04, 32'hA5);
        rdchk(8'h04, 32'h00);
    endtask
    // Every external channel and both references, polled by done flag.
    task automatic t_chan();
        logic [4:0] ch;
        wr(8'h08, 32'h10);
        wr(8'h00, 32'h00);
        wait_done();
        for (int i = 0; i < 17; i++) begin
            ch = (i < 15) ? 5'(i) : ((i == 15) ? 5'h1D : 5'h1E);
            wr(8'h00, {27'h0, ch});
            @(posedge pclk);
            chk({input_channel_select, ext_channel_en, high_ref_sel,
                low_ref_sel}, {ch, i < 15, ch == 5'h1D, ch == 5'h1E});
            chk(converter_power_on, 1'b1);
            wait_done();
            rdchk(8'h00, {24'h0, 3'b100, ch});
            rdchk(8'h04, (i < 15) ? 32'(8'(8'h11 * i + 3)) :
                ((i == 15) ? 32'hFF : 32'h00));
            rdchk(8'h00, {27'h0, ch});
        end
    endtask
    // Every divider code with the bus clock, timed by the interrupt.
    task automatic t_div();
        int n, r;
        for (int c = 0; c < 8; c++) begin
            r = (c > 3) ? 16 : (1 << c);
            wr(8'h08, {24'h0, 3'(c), 5'h10});
            wr(8'h00, 32'h42);
            wait_irq(n);
            chk_rng(n, 15 * r, 17 * r + 8);
            rdchk(8'h00, 32'h42);
            rdchk(8'h04, 32'h25);
            chk(conv_irq, 1'b0);
        end
    endtask
    task automatic t_cont();
        wr(8'h08, 32'h10);
        wr(8'h00, 32'h24);
        wait_done();
        rdchk(8'h04, 32'h47);
        wait_done();
        wr(8'h00, 32'h04);
        rdchk(8'h00, 32'h04);
        wait_done();
        rdchk(8'h04, 32'h47);
        repeat (60) @(posedge pclk);
        rdchk(8'h00, 32'h04);
    endtask
    task automatic t_stop();
        int n;
        wr(8'h08, 32'h90);
        wr(8'h00, 32'h41);
        repeat (50) @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (400) @(posedge pclk);
        chk(conv_irq, 1'b0);
        stop_mode <= 1'b0;
        wait_irq(n);
        chk_rng(n, 1, 300);
        rdchk(8'h04, 32'h14);
    endtask
    task automatic t_ref_off();
        int n;
        wr(8'h08, 32'h80);
        wr(8'h00, 32'h41);
        wait_irq(n);
        chk_rng(n, 930, 1030);
        wr(8'h00, 32'h1F);
        @(posedge pclk);
        chk(converter_power_on, 1'b0);
        repeat (200) @(posedge pclk);
        rdchk(8'h00, 32'h1F);
        chk(conv_irq, 1'b0);
    endtask
    // =========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_chan();
        t_div();
        t_cont();
        t_stop();
        t_ref_off();
        wrap_up();
    end
endmodule
